// ===== common/fcf_params.svh
`ifndef FCF_PARAMS_SVH
`define FCF_PARAMS_SVH

// ----------------------------------------------------------------
// link timing
// ----------------------------------------------------------------
// forwarded clock half period (one bit time) in core clocks
`define FCF_BIT_DIV 4'h4
// core clocks the forwarded clock stays stopped after interface reset
`define FCF_RESTART_CYC 8'h10
// mux / flop entries (command/address is four bit times)
`define FCF_MUX_ENTRIES 4
// frame ratio encodings: bit times per framing clock half period
`define FCF_FRAME_1X 2'h0
`define FCF_FRAME_2X 2'h1
`define FCF_FRAME_4X 2'h2
// receive mux counter preset
`define FCF_RX_PRESET 2'h0

`endif

// ===== common/fcf_pkg.sv
package fcf_pkg;
	typedef enum logic [1:0] {
		FCF_ST_STOP = 2'b00,
		FCF_ST_WAIT = 2'b01,
		FCF_ST_RUN = 2'b11
	} fcf_state_t;
	typedef logic [1:0] fcf_ratio_t;
endpackage : fcf_pkg

// ===== common/fcf_link_if.sv
`timescale 1ns/1ps
interface fcf_link_if #(parameter int W = 8);
	logic fwd_clk;
	logic frame_clk;
	logic [W-1:0] data;
	logic ifc_rst;
	modport dev (output fwd_clk, output data, input frame_clk, input ifc_rst);
	modport sys (input fwd_clk, input data, output frame_clk, output ifc_rst);
endinterface : fcf_link_if

// ===== rtl/fcf_fifo.sv
`timescale 1ns/1ps
module fcf_fifo #(
	parameter int W = 8,
	parameter int D = 16
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// fill side
	input wire logic i_valid,
	output logic o_ready,
	input wire logic [W-1:0] i_data,
	// drain side
	output logic o_valid,
	input wire logic i_ready,
	output logic [W-1:0] o_data
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic full, empty;

	assign empty = (wp_r == rp_r);
	assign full = (wp_r[AW-1:0] == rp_r[AW-1:0]) && (wp_r[AW] != rp_r[AW]);
	assign o_ready = !full;
	assign o_valid = !empty;
	assign o_data = mem[rp_r[AW-1:0]];

	always_comb begin
		wp_nxt = wp_r + (AW+1)'(i_valid && !full);
		rp_nxt = rp_r + (AW+1)'(i_ready && !empty);
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			wp_r <= '0;
			rp_r <= '0;
		end else begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
		end
		if (i_valid && !full)
			mem[wp_r[AW-1:0]] <= i_data;
	end
endmodule : fcf_fifo

// ===== rtl/fcf_dev_end.sv
`timescale 1ns/1ps
`include "fcf_params.svh"
module fcf_dev_end import fcf_pkg::*; #(
	parameter int W = 8,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// configuration
	input wire logic [1:0] i_frame_sel,
	// outgoing word stream
	input wire logic i_valid,
	output logic o_ready,
	input wire logic [W-1:0] i_data,
	// status
	output logic o_running,
	output logic [1:0] o_out_mux_cnt,
	output logic [1:0] o_rx_cnt,
	// link
	fcf_link_if.dev link
);
	// ----------------------------------------------------------------
	// pin synchronisers (three flops, change seen when 2 and 3 agree)
	// ----------------------------------------------------------------
	logic [2:0] fr_s_r, rs_s_r;
	logic fr_lvl_r, rs_lvl_r;
	logic [2:0] fr_s_nxt, rs_s_nxt;
	logic fr_lvl_nxt, rs_lvl_nxt;
	always_comb begin
		fr_s_nxt = {fr_s_r[1:0], link.frame_clk};
		rs_s_nxt = {rs_s_r[1:0], link.ifc_rst};
		fr_lvl_nxt = (fr_s_r[1] == fr_s_r[2]) ? fr_s_r[2] : fr_lvl_r;
		rs_lvl_nxt = (rs_s_r[1] == rs_s_r[2]) ? rs_s_r[2] : rs_lvl_r;
	end
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			fr_s_r <= 3'h0;
			rs_s_r <= 3'h0;
			fr_lvl_r <= 1'b0;
			rs_lvl_r <= 1'b0;
		end else begin
			fr_s_r <= fr_s_nxt;
			rs_s_r <= rs_s_nxt;
			fr_lvl_r <= fr_lvl_nxt;
			rs_lvl_r <= rs_lvl_nxt;
		end
	end
	// both framing edges mark a start boundary
	logic frame_edge;
	assign frame_edge = (fr_lvl_nxt != fr_lvl_r);

	// ----------------------------------------------------------------
	// transmit buffer
	// ----------------------------------------------------------------
	logic f_valid, f_pop;
	logic [W-1:0] f_data;
	fcf_fifo #(.W(W), .D(DEPTH)) u_fifo (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_valid(i_valid),
		.o_ready(o_ready),
		.i_data(i_data),
		.o_valid(f_valid),
		.i_ready(f_pop),
		.o_data(f_data)
	);

	// ----------------------------------------------------------------
	// clock forwarding control
	// ----------------------------------------------------------------
	fcf_state_t st_r, st_nxt;
	logic [7:0] wait_r, wait_nxt;
	logic [3:0] div_r, div_nxt;
	logic fwd_r, fwd_nxt;
	logic [1:0] omux_r, omux_nxt;
	logic [1:0] rx_r, rx_nxt;
	logic [1:0] rxmux_r, rxmux_nxt;
	logic [2:0] bits_r, bits_nxt;
	logic busy_r, busy_nxt;
	logic [W-1:0] dout_r, dout_nxt;
	logic [2:0] frame_bits;
	logic bit_tick;
	logic edge_seen_r, edge_seen_nxt;
	logic frame_start;

	// bit times per framing half period: power of two set by the ratio
	function automatic logic [2:0] fcf_frame_bits(input logic [1:0] sel);
		case (sel)
			`FCF_FRAME_1X: fcf_frame_bits = 3'h1;
			`FCF_FRAME_2X: fcf_frame_bits = 3'h2;
			`FCF_FRAME_4X: fcf_frame_bits = 3'h4;
			default: fcf_frame_bits = 3'h1;
		endcase
	endfunction : fcf_frame_bits

	assign frame_bits = fcf_frame_bits(i_frame_sel);
	assign bit_tick = (st_r == FCF_ST_RUN) && (div_r == `FCF_BIT_DIV - 4'h1);
	// boundary: an edge seen since the last bit tick, or one the ratio count predicts
	assign frame_start = frame_edge || edge_seen_r || (bits_r == 3'h1);
	// a word leaves only on a bit tick, at a framing boundary or while a burst is running
	assign f_pop = bit_tick && f_valid && (busy_r || frame_start);

	always_comb begin
		st_nxt = st_r;
		wait_nxt = wait_r;
		div_nxt = div_r;
		fwd_nxt = fwd_r;
		omux_nxt = omux_r;
		rx_nxt = rx_r;
		rxmux_nxt = rxmux_r;
		bits_nxt = bits_r;
		busy_nxt = busy_r;
		dout_nxt = dout_r;
		edge_seen_nxt = edge_seen_r;
		case (st_r)
			FCF_ST_STOP: begin
				// clocks held, counters preset
				fwd_nxt = 1'b0;
				div_nxt = 4'h0;
				omux_nxt = 2'h0;
				rx_nxt = 2'h0;
				rxmux_nxt = `FCF_RX_PRESET;
				busy_nxt = 1'b0;
				bits_nxt = 3'h0;
				edge_seen_nxt = 1'b0;
				dout_nxt = '0;
				wait_nxt = 8'h0;
				if (!rs_lvl_r)
					st_nxt = FCF_ST_WAIT;
			end
			FCF_ST_WAIT: begin
				wait_nxt = wait_r + 8'h1;
				if (rs_lvl_r)
					st_nxt = FCF_ST_STOP;
				else if (wait_r == `FCF_RESTART_CYC - 8'h1)
					st_nxt = FCF_ST_RUN;
			end
			FCF_ST_RUN: begin
				if (rs_lvl_r) begin
					st_nxt = FCF_ST_STOP;
					fwd_nxt = 1'b0;
				end else begin
					// the framing edge is a one-cycle pulse: hold it until the next bit tick
					if (frame_edge)
						edge_seen_nxt = 1'b1;
					// even divider: equal high and low times
					div_nxt = bit_tick ? 4'h0 : div_r + 4'h1;
					if (bit_tick) begin
						fwd_nxt = !fwd_r;
						omux_nxt = omux_r + 2'h1;
						rx_nxt = rx_r + 2'h1;
						rxmux_nxt = rxmux_r + 2'h1;
						// data changes with the clock edge; zero is the idle word
						dout_nxt = f_pop ? f_data : '0;
						// boundary consumed here; the ratio count predicts the next one
						edge_seen_nxt = 1'b0;
						if (frame_start)
							bits_nxt = frame_bits;
						else if (bits_r != 3'h0)
							bits_nxt = bits_r - 3'h1;
						// burst continues past a frame boundary if longer
						busy_nxt = f_pop;
					end
				end
			end
			default: st_nxt = FCF_ST_STOP;
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			st_r <= FCF_ST_STOP;
			wait_r <= 8'h0;
			div_r <= 4'h0;
			fwd_r <= 1'b0;
			omux_r <= 2'h0;
			rx_r <= 2'h0;
			rxmux_r <= 2'h0;
			bits_r <= 3'h0;
			busy_r <= 1'b0;
			dout_r <= '0;
			edge_seen_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			wait_r <= wait_nxt;
			div_r <= div_nxt;
			fwd_r <= fwd_nxt;
			omux_r <= omux_nxt;
			rx_r <= rx_nxt;
			rxmux_r <= rxmux_nxt;
			bits_r <= bits_nxt;
			busy_r <= busy_nxt;
			dout_r <= dout_nxt;
			edge_seen_r <= edge_seen_nxt;
		end
	end

	assign link.fwd_clk = fwd_r;
	assign link.data = dout_r;
	assign o_running = (st_r == FCF_ST_RUN);
	assign o_out_mux_cnt = omux_r;
	assign o_rx_cnt = rx_r;
endmodule : fcf_dev_end

// ===== rtl/fcf_sys_end.sv
`timescale 1ns/1ps
`include "fcf_params.svh"
module fcf_sys_end import fcf_pkg::*; #(
	parameter int W = 8,
	parameter int FRAME_DIV = 16
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// control
	input wire logic i_ifc_rst,
	// received words
	output logic o_valid,
	output logic [W-1:0] o_data,
	// link
	fcf_link_if.sys link
);
	// ----------------------------------------------------------------
	// framing clock: both edges are boundaries
	// ----------------------------------------------------------------
	logic [7:0] fdiv_r, fdiv_nxt;
	logic frame_r, frame_nxt, rst_r, rst_nxt;
	logic [2:0] ck_s_r, ck_s_nxt;
	logic ck_lvl_r, ck_lvl_nxt;
	logic vld_r, vld_nxt;
	logic [W-1:0] dat_r, dat_nxt;
	always_comb begin
		fdiv_nxt = (fdiv_r == 8'(FRAME_DIV - 1)) ? 8'h0 : fdiv_r + 8'h1;
		frame_nxt = (fdiv_r == 8'(FRAME_DIV - 1)) ? !frame_r : frame_r;
		rst_nxt = i_ifc_rst;
		ck_s_nxt = {ck_s_r[1:0], link.fwd_clk};
		ck_lvl_nxt = (ck_s_r[1] == ck_s_r[2]) ? ck_s_r[2] : ck_lvl_r;
		// capture on both forwarded clock edges
		vld_nxt = (ck_lvl_nxt != ck_lvl_r) && !rst_r;
		dat_nxt = vld_nxt ? link.data : dat_r;
	end
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			fdiv_r <= 8'h0;
			frame_r <= 1'b0;
			rst_r <= 1'b1;
			ck_s_r <= 3'h0;
			ck_lvl_r <= 1'b0;
			vld_r <= 1'b0;
			dat_r <= '0;
		end else begin
			fdiv_r <= fdiv_nxt;
			frame_r <= frame_nxt;
			rst_r <= rst_nxt;
			ck_s_r <= ck_s_nxt;
			ck_lvl_r <= ck_lvl_nxt;
			vld_r <= vld_nxt;
			dat_r <= dat_nxt;
		end
	end
	assign link.frame_clk = frame_r;
	assign link.ifc_rst = rst_r;
	assign o_valid = vld_r;
	assign o_data = dat_r;
endmodule : fcf_sys_end

// ===== verif/fcf_link_properties.sv
`timescale 1ns/1ps
module fcf_link_properties #(
	parameter int W = 8
) (
	// core clock
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// link
	input wire logic fwd_clk,
	input wire logic frame_clk,
	input wire logic [W-1:0] data,
	input wire logic ifc_rst
);
	// ----------------
	// settle age
	// ----------------
	// 15 clocks after interface reset the dev end has seen its release
	logic [3:0] age_r;
	logic [3:0] age_nxt;
	always_comb begin
		age_nxt = age_r;
		if (i_sys_rst || ifc_rst)
			age_nxt = 4'h0;
		else if (age_r != 4'hf)
			age_nxt = age_r + 4'h1;
	end
	always_ff @(posedge i_clk) begin
		age_r <= age_nxt;
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	// ----------------
	// properties
	// ----------------
	property p_stop; ifc_rst [*6] |-> !fwd_clk; endproperty
	a_stop: assert property (p_stop) else $error("fwd clock runs in reset");
	property p_hold; $fell(ifc_rst) |-> !fwd_clk [*8]; endproperty
	a_hold: assert property (p_hold) else $error("early restart");
	property p_hi; disable iff (i_sys_rst || ifc_rst)
		age_r == 4'hf && $rose(fwd_clk) |-> fwd_clk [*4] ##1 !fwd_clk; endproperty
	a_hi: assert property (p_hi) else $error("bad high phase");
	property p_lo; disable iff (i_sys_rst || ifc_rst)
		age_r == 4'hf && $fell(fwd_clk) |-> !fwd_clk [*4] ##1 fwd_clk; endproperty
	a_lo: assert property (p_lo) else $error("bad low phase");
	property p_edge; age_r == 4'hf && $changed(data) |-> $changed(fwd_clk); endproperty
	a_edge: assert property (p_edge) else $error("data off clock edge");
	property p_stand; age_r == 4'hf && $changed(data) |=> $stable(data) [*3]; endproperty
	a_stand: assert property (p_stand) else $error("data short");
	property p_sysrst; $fell(i_sys_rst) |-> ifc_rst; endproperty
	a_sysrst: assert property (p_sysrst) else $error("no interface reset");
	property p_frun; !ifc_rst |-> ##[1:40] $changed(frame_clk); endproperty
	a_frun: assert property (p_frun) else $error("framing clock stuck");
	property p_fmin; $changed(frame_clk) |=> $stable(frame_clk) [*3]; endproperty
	a_fmin: assert property (p_fmin) else $error("framing too fast");
endmodule : fcf_link_properties

// ===== verif/test_forwarded_clock_framing_reset.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module test_forwarded_clock_framing_reset;
	logic i_clk = 1'b0;
	logic i_sys_rst = 1'b1;
	logic i_ifc_rst = 1'b0;
	logic [1:0] i_frame_sel = 2'h0;
	logic i_valid = 1'b0;
	logic [7:0] i_data = 8'h00;
	logic o_ready, o_running, o_valid;
	logic [1:0] o_out_mux_cnt, o_rx_cnt;
	logic [7:0] o_data;
	logic [7:0] rxq[$];
	int n_fail = 0;
	int checks_done = 0;
	int cyc = 0;
	always #2.5 i_clk = ~i_clk;
	fcf_link_if fcf_link_if_inst ();
	fcf_dev_end #(.W(8), .DEPTH(16)) fcf_dev_end_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
		.i_frame_sel(i_frame_sel), .i_valid(i_valid), .o_ready(o_ready), .i_data(i_data),
		.o_running(o_running), .o_out_mux_cnt(o_out_mux_cnt), .o_rx_cnt(o_rx_cnt),
		.link(fcf_link_if_inst.dev));
	fcf_sys_end #(.W(8), .FRAME_DIV(16)) fcf_sys_end_inst (.i_clk(i_clk),
		.i_sys_rst(i_sys_rst), .i_ifc_rst(i_ifc_rst), .o_valid(o_valid), .o_data(o_data),
		.link(fcf_link_if_inst.sys));
	fcf_link_properties #(.W(8)) fcf_link_properties_inst (.i_clk(i_clk),
		.i_sys_rst(i_sys_rst), .fwd_clk(fcf_link_if_inst.fwd_clk),
		.frame_clk(fcf_link_if_inst.frame_clk), .data(fcf_link_if_inst.data),
		.ifc_rst(fcf_link_if_inst.ifc_rst));
	// ----------------
	// helpers
	// ----------------
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : final_report
	// collect words and cut a hang short; a zero word cannot be told from idle
	always @(negedge i_clk) begin
		cyc++;
		if (!i_sys_rst && o_valid === 1'b1 && o_data !== 8'h00)
			rxq.push_back(o_data);
		if (cyc == 20000) begin
			n_fail++;
			final_report();
		end
	end
	// called at a falling edge, returns once the word was taken
	task automatic push(input logic [7:0] d);
		i_valid = 1'b1;
		i_data = d;
		while (o_ready !== 1'b1) @(negedge i_clk);
		@(negedge i_clk);
	endtask : push
	task automatic wait_run(output int n);
		for (n = 0; n < 300 && o_running !== 1'b1; n++) @(negedge i_clk);
	endtask : wait_run
	task automatic expect_words(input logic [7:0] base, input int n);
		logic [7:0] w;
		for (int k = 0; k < 3000 && rxq.size() < n; k++) @(negedge i_clk);
		`CHK(rxq.size(), n)
		for (int i = 0; i < n && rxq.size() > 0; i++) begin
			w = rxq.pop_front();
			`CHK(w, 8'(base + i))
		end
	endtask : expect_words
	// ----------------
	// scenarios
	// ----------------
	// words queued under interface reset must wait, then drain in order
	task automatic t_reset_fill();
		int n;
		i_ifc_rst = 1'b1;
		repeat (20) @(negedge i_clk);
		`CHK(o_running, 1'b0)
		`CHK(o_out_mux_cnt, 2'h0)
		`CHK(o_rx_cnt, 2'h0)
		for (int i = 0; i < 16; i++)
			push(8'(8'h40 + i));
		`CHK(o_ready, 1'b0)
		i_valid = 1'b0;
		repeat (4) @(negedge i_clk);
		`CHK(rxq.size(), 0)
		i_ifc_rst = 1'b0;
		wait_run(n);
		`CHK(n >= 16 && n < 300, 1'b1)
		expect_words(8'h40, 16);
	endtask : t_reset_fill
	// bursts of six words cross mux wrap and frame boundaries
	task automatic t_ratio(input logic [1:0] sel);
		logic [1:0] c0, r0;
		logic prev;
		int nt;
		i_frame_sel = sel;
		repeat (64) @(negedge i_clk);
		for (int i = 0; i < 6; i++)
			push(8'(8'h80 + 8'h10 * sel + i));
		i_valid = 1'b0;
		expect_words(8'(8'h80 + 8'h10 * sel), 6);
		// every forwarded clock edge steps both counters, wrapping mod 4
		c0 = o_out_mux_cnt;
		r0 = o_rx_cnt;
		prev = fcf_link_if_inst.fwd_clk;
		nt = 0;
		repeat (40) begin
			@(negedge i_clk);
			if (fcf_link_if_inst.fwd_clk !== prev)
				nt++;
			prev = fcf_link_if_inst.fwd_clk;
		end
		`CHK(o_out_mux_cnt, 2'(c0 + 2'(nt)))
		`CHK(o_rx_cnt, 2'(r0 + 2'(nt)))
		`CHK(nt, 10)
	endtask : t_ratio
	initial begin
		int n;
		repeat (4) @(negedge i_clk);
		i_sys_rst = 1'b0;
		wait_run(n);
		`CHK(o_running, 1'b1)
		rxq.delete();
		t_reset_fill();
		for (int s = 0; s < 3; s++)
			t_ratio(2'(s));
		final_report();
	end
endmodule : test_forwarded_clock_framing_reset
